/* verilog/idac_pkg.sv */
package idac_pkg;

    // geometry of the register bank
    localparam int unsigned IDAC_CODE_W = 8;
    localparam int unsigned IDAC_NUM_CH = 5;
    localparam int unsigned IDAC_NUM_PORT = 4;
    localparam int unsigned IDAC_PTR_W = 3;

    // sub address decode, low three bits only
    localparam logic [2:0] IDAC_SUB_CTRL = 3'h0;
    localparam logic [2:0] IDAC_SUB_CH_FIRST = 3'h1;
    localparam logic [2:0] IDAC_SUB_CH_LAST = 3'h5;

    // control byte fields
    localparam int unsigned IDAC_CTRL_SCALE_BIT = 7;
    localparam int unsigned IDAC_CTRL_PORT_LSB = 0;

    // status byte fields
    localparam int unsigned IDAC_STAT_LOSS_BIT = 7;
    localparam logic [2:0] IDAC_STAT_PAD = 3'h0;

    // reset values
    localparam logic [7:0] IDAC_CTRL_RST = 8'h00;
    localparam logic [7:0] IDAC_CODE_RST = 8'h00;
    localparam logic IDAC_LOSS_RST = 1'b1;

    // serial framing
    localparam logic [3:0] IDAC_BITS_BYTE = 4'h8;
    localparam logic [3:0] IDAC_BIT_ONE = 4'h1;
    localparam logic [3:0] IDAC_BIT_ZERO = 4'h0;
    localparam logic [6:0] IDAC_ADDR_HI_DEF = 7'h28;

    // bus timing kept by the controller, for reference; no check refers to it
    localparam int unsigned IDAC_CLK_MHZ = 125;
    localparam real IDAC_T_LOW_US = 4.7;
    localparam real IDAC_T_HIGH_US = 4.0;
    localparam int unsigned IDAC_T_LOW_CYC = int'($ceil(IDAC_T_LOW_US * IDAC_CLK_MHZ));
    localparam int unsigned IDAC_T_HIGH_CYC = int'($ceil(IDAC_T_HIGH_US * IDAC_CLK_MHZ));

    // transfer phases of the serial slave
    typedef enum logic [3:0] {
        IDAC_IDLE,
        IDAC_ADDR,
        IDAC_ADDR_ACK,
        IDAC_SUB,
        IDAC_SUB_ACK,
        IDAC_WDATA,
        IDAC_WDATA_ACK,
        IDAC_RDATA,
        IDAC_RACK,
        IDAC_IGNORE
    } idac_phase_t;

endpackage

/* verilog/idac_edge.sv */
`timescale 1ns/10ps
module idac_edge
    import idac_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // sampled line
    input wire logic line_in,
    // registered level and edge pulses
    output logic level,
    output logic rise,
    output logic fall
);

    typedef struct packed {
        logic prev;
    } idac_edge_state_t;

    idac_edge_state_t s_q;
    idac_edge_state_t s_d;

    // lines idle high, so reset to high to avoid a false rise
    always_comb begin
        s_d = s_q;
        s_d.prev = line_in;
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            s_q <= '{prev: 1'b1};
        end else begin
            s_q <= s_d;
        end
    end

    assign level = s_q.prev;
    assign rise = line_in & ~s_q.prev;
    assign fall = ~line_in & s_q.prev;

endmodule

/* verilog/idac_top.sv */
// Function
// - reset clears control and channel codes
// - pointer advances after every data byte
// - only low three sub address bits decode
// - control bit7 scale, bits3..0 port drives
// - scale bit picks regulator or supply divider
// - drive bit one turns port sink on
// - channel code is 8-bit unsigned
// - status: loss flag, zeros, port levels
// - loss flag sets on power-up or dip
// - loss clears after status read and stop
// - level bit reports sensed pin level
// - start and stop frame every transfer
// - data line only pulled low or released
// - id pins match low address bits
`timescale 1ns/10ps
module idac_top
    import idac_pkg::*;
#(
    parameter logic [6:0] ADDR_HI = IDAC_ADDR_HI_DEF // arbitrary upper address bits
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // serial bus
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_b,
    // address select pins
    input wire logic slave_id_pin0,
    input wire logic slave_id_pin1,
    input wire logic slave_id_pin2,
    // supply monitor event
    input wire logic supply_dip,
    // open-collector ports
    input wire logic [IDAC_NUM_PORT-1:0] port_level_in,
    output logic [IDAC_NUM_PORT-1:0] port_out,
    output logic [IDAC_NUM_PORT-1:0] port_drive_oe_b,
    // converter controls
    output logic scale_from_supply,
    output logic [IDAC_CODE_W-1:0] channel0_code,
    output logic [IDAC_CODE_W-1:0] channel1_code,
    output logic [IDAC_CODE_W-1:0] channel2_code,
    output logic [IDAC_CODE_W-1:0] channel3_code,
    output logic [IDAC_CODE_W-1:0] channel4_code,
    // status view
    output logic supply_loss_flag
);

    typedef struct packed {
        idac_phase_t ph;
        logic [3:0] bits;
        logic [7:0] shift;
        logic [IDAC_PTR_W-1:0] ptr;
        logic [7:0] control_byte;
        logic [IDAC_NUM_CH-1:0][IDAC_CODE_W-1:0] channel_code_regs;
        logic loss;
        logic rd_done;
        logic drive_low;
        logic rw;
        logic mnack;
    } idac_state_t;

    idac_state_t s_q;
    idac_state_t s_d;

    logic scl_lvl;
    logic scl_rise;
    logic scl_fall;
    logic sda_lvl;
    logic sda_rise;
    logic sda_fall;
    logic start_ev;
    logic stop_ev;
    logic [6:0] my_addr;
    logic [7:0] status_byte;
    logic byte_full;

    ////////////////////////////////////////////////////////////////////////////
    // line sampling

    idac_edge u_scl_edge (
        .clk(clk),
        .rst_b(rst_b),
        .line_in(scl_in),
        .level(scl_lvl),
        .rise(scl_rise),
        .fall(scl_fall)
    );

    idac_edge u_sda_edge (
        .clk(clk),
        .rst_b(rst_b),
        .line_in(sda_in),
        .level(sda_lvl),
        .rise(sda_rise),
        .fall(sda_fall)
    );

    // data moving while clock stays high marks frame edges
    assign start_ev = sda_fall & scl_lvl & scl_in;
    assign stop_ev = sda_rise & scl_lvl & scl_in;
    assign my_addr = {ADDR_HI[6:3], slave_id_pin2, slave_id_pin1, slave_id_pin0};
    assign status_byte = {s_q.loss, IDAC_STAT_PAD, port_level_in};
    assign byte_full = (s_q.bits == IDAC_BITS_BYTE);

    ////////////////////////////////////////////////////////////////////////////
    // sub address decode

    // upper five bits never reach here; six and seven hit nothing
    function automatic logic is_channel(input logic [IDAC_PTR_W-1:0] p);
        is_channel = (p >= IDAC_SUB_CH_FIRST) && (p <= IDAC_SUB_CH_LAST);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // transfer state machine

    always_comb begin
        s_d = s_q;
        if (start_ev) begin
            // a repeated start restarts addressing without a stop
            s_d.ph = IDAC_ADDR;
            s_d.bits = IDAC_BIT_ZERO;
            s_d.drive_low = 1'b0;
        end else if (stop_ev) begin
            s_d.ph = IDAC_IDLE;
            s_d.drive_low = 1'b0;
            s_d.rd_done = 1'b0;
            if (s_q.rd_done) begin
                s_d.loss = 1'b0;
            end
        end else if (scl_rise) begin
            case (s_q.ph)
                IDAC_ADDR, IDAC_SUB, IDAC_WDATA: begin
                    s_d.shift = {s_q.shift[6:0], sda_in};
                    s_d.bits = s_q.bits + IDAC_BIT_ONE;
                end
                IDAC_RACK: begin
                    s_d.mnack = sda_in;
                end
                default: begin
                end
            endcase
        end else if (scl_fall) begin
            case (s_q.ph)
                IDAC_ADDR: begin
                    if (byte_full && (s_q.shift[7:1] == my_addr)) begin
                        s_d.ph = IDAC_ADDR_ACK;
                        s_d.drive_low = 1'b1;
                        s_d.rw = s_q.shift[0];
                    end else if (byte_full) begin
                        s_d.ph = IDAC_IGNORE;
                    end
                end
                IDAC_ADDR_ACK: begin
                    s_d.bits = IDAC_BIT_ZERO;
                    if (s_q.rw) begin
                        s_d.ph = IDAC_RDATA;
                        s_d.shift = status_byte;
                        s_d.drive_low = ~status_byte[7];
                        s_d.bits = IDAC_BIT_ONE;
                    end else begin
                        s_d.ph = IDAC_SUB;
                        s_d.drive_low = 1'b0;
                    end
                end
                IDAC_SUB: begin
                    if (byte_full) begin
                        s_d.ptr = s_q.shift[IDAC_PTR_W-1:0];
                        s_d.ph = IDAC_SUB_ACK;
                        s_d.drive_low = 1'b1;
                    end
                end
                IDAC_SUB_ACK, IDAC_WDATA_ACK: begin
                    s_d.ph = IDAC_WDATA;
                    s_d.bits = IDAC_BIT_ZERO;
                    s_d.drive_low = 1'b0;
                end
                IDAC_WDATA: begin
                    if (byte_full) begin
                        // unmapped pointers still ack but store nothing
                        if (s_q.ptr == IDAC_SUB_CTRL) begin
                            s_d.control_byte = s_q.shift;
                        end else if (is_channel(s_q.ptr)) begin
                            s_d.channel_code_regs[s_q.ptr - IDAC_SUB_CH_FIRST] = s_q.shift;
                        end
                        s_d.ptr = s_q.ptr + 3'h1;
                        s_d.ph = IDAC_WDATA_ACK;
                        s_d.drive_low = 1'b1;
                    end
                end
                IDAC_RDATA: begin
                    if (byte_full) begin
                        s_d.ph = IDAC_RACK;
                        s_d.drive_low = 1'b0;
                        s_d.rd_done = 1'b1;
                    end else begin
                        s_d.drive_low = ~s_q.shift[6];
                        s_d.shift = {s_q.shift[6:0], 1'b0};
                        s_d.bits = s_q.bits + IDAC_BIT_ONE;
                    end
                end
                IDAC_RACK: begin
                    if (s_q.mnack) begin
                        s_d.ph = IDAC_IGNORE;
                    end else begin
                        s_d.ph = IDAC_RDATA;
                        s_d.shift = status_byte;
                        s_d.drive_low = ~status_byte[7];
                        s_d.bits = IDAC_BIT_ONE;
                    end
                end
                default: begin
                end
            endcase
        end
        // a dip in the same cycle as a clear must not be lost
        if (supply_dip) begin
            s_d.loss = 1'b1;
        end
    end

    // power-up comes through reset, so the loss flag resets to one
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            s_q.ph <= IDAC_IDLE;
            s_q.bits <= IDAC_BIT_ZERO;
            s_q.shift <= 8'h00;
            s_q.ptr <= IDAC_SUB_CTRL;
            s_q.control_byte <= IDAC_CTRL_RST;
            s_q.channel_code_regs <= {IDAC_NUM_CH{IDAC_CODE_RST}};
            s_q.loss <= IDAC_LOSS_RST;
            s_q.rd_done <= 1'b0;
            s_q.drive_low <= 1'b0;
            s_q.rw <= 1'b0;
            s_q.mnack <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    // the data line is never driven high; release lets the pull-up win
    assign sda_out = 1'b0;
    assign sda_oe_b = ~s_q.drive_low;
    // a cleared drive bit leaves the pin free for sensing
    assign port_out = '0;
    assign port_drive_oe_b = ~s_q.control_byte[IDAC_CTRL_PORT_LSB +: IDAC_NUM_PORT];
    assign scale_from_supply = s_q.control_byte[IDAC_CTRL_SCALE_BIT];
    assign channel0_code = s_q.channel_code_regs[0];
    assign channel1_code = s_q.channel_code_regs[1];
    assign channel2_code = s_q.channel_code_regs[2];
    assign channel3_code = s_q.channel_code_regs[3];
    assign channel4_code = s_q.channel_code_regs[4];
    assign supply_loss_flag = s_q.loss;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    logic wr_store;
    assign wr_store = (s_q.ph == IDAC_WDATA) && byte_full && scl_fall && !start_ev && !stop_ev;

    // a falling clock with no frame edge in the same cycle
    logic fall_only;
    assign fall_only = scl_fall && !start_ev && !stop_ev;

    a_reset_clears: assert property (disable iff (1'b0) !rst_b |=>
        (s_q.control_byte == IDAC_CTRL_RST) && (channel2_code == IDAC_CODE_RST) && s_q.loss)
        else $error("reset did not clear the bank");
    a_ptr_advance: assert property (wr_store |=> s_q.ptr == $past(s_q.ptr) + 3'h1)
        else $error("pointer did not advance");
    a_sub_decode: assert property ((s_q.ph == IDAC_SUB) && byte_full && scl_fall
        && !start_ev && !stop_ev |=> s_q.ptr == $past(s_q.shift[2:0]))
        else $error("sub address decode wrong");
    a_ctrl_steers: assert property (wr_store && (s_q.ptr == IDAC_SUB_CTRL) |=>
        (scale_from_supply == $past(s_q.shift[7])) && (port_drive_oe_b == ~$past(s_q.shift[3:0])))
        else $error("control byte did not steer outputs");
    a_chan_store: assert property (wr_store && (s_q.ptr == 3'h3) |=>
        channel2_code == $past(s_q.shift))
        else $error("channel code not stored");
    a_status_load: assert property ((s_q.ph == IDAC_ADDR_ACK) && s_q.rw && scl_fall
        && !start_ev && !stop_ev |=> s_q.shift == {$past(s_q.loss), 3'h0, $past(port_level_in)})
        else $error("status byte layout wrong");
    a_loss_set: assert property (supply_dip |=> supply_loss_flag)
        else $error("loss flag not set");
    a_loss_clear: assert property (stop_ev && s_q.rd_done && !supply_dip |=>
        !supply_loss_flag ##1 !supply_loss_flag || $past(supply_dip))
        else $error("loss flag not cleared after read");
    a_start_frame: assert property (start_ev |=> (s_q.ph == IDAC_ADDR) && !s_q.drive_low)
        else $error("start did not open addressing");
    a_sda_owner: assert property (s_q.drive_low |-> s_q.ph inside
        {IDAC_ADDR_ACK, IDAC_SUB_ACK, IDAC_WDATA_ACK, IDAC_RDATA})
        else $error("data line pulled low out of turn");
    a_addr_miss: assert property ((s_q.ph == IDAC_ADDR) && byte_full && scl_fall
        && !start_ev && !stop_ev && (s_q.shift[7:1] != my_addr) |=> s_q.ph == IDAC_IGNORE)
        else $error("foreign address acknowledged");

    // read side: bits leave at each fall, a not-acknowledge hands the line back
    a_read_shift: assert property ((s_q.ph == IDAC_RDATA) && fall_only && !byte_full |=>
        s_q.drive_low == !$past(s_q.shift[6]))
        else $error("read bit not shifted out");
    a_read_nack: assert property ((s_q.ph == IDAC_RACK) && fall_only && s_q.mnack |=>
        (s_q.ph == IDAC_IGNORE) && !s_q.drive_low)
        else $error("line held after not-acknowledge");
    // write side: every byte is acknowledged for exactly one clock
    a_sub_ack: assert property ((s_q.ph == IDAC_SUB) && byte_full && fall_only |=>
        (s_q.ph == IDAC_SUB_ACK) && s_q.drive_low)
        else $error("sub address not acknowledged");
    a_ack_release: assert property ((s_q.ph == IDAC_WDATA_ACK) && fall_only |=>
        (s_q.ph == IDAC_WDATA) && !s_q.drive_low && (s_q.bits == IDAC_BIT_ZERO))
        else $error("data acknowledge not released");
    // frame end and the loss flag, which only a stop may clear
    a_stop_frame: assert property (stop_ev |=> (s_q.ph == IDAC_IDLE) && !s_q.drive_low)
        else $error("stop did not close the frame");
    a_loss_hold: assert property (!stop_ev |=> !$fell(supply_loss_flag))
        else $error("loss flag cleared outside a stop");

    // main scenarios, each reached by the bench
    c_write_byte: cover property (wr_store && (s_q.ptr == IDAC_SUB_CH_LAST));
    c_ptr_wrap: cover property (wr_store && (s_q.ptr == 3'h7));
    c_read_status: cover property ((s_q.ph == IDAC_RACK) && scl_fall && s_q.mnack);
    c_loss_cleared: cover property (stop_ev && s_q.rd_done);
    c_repeat_start: cover property (start_ev && (s_q.ph != IDAC_IDLE));

endmodule

/* test/idac_mst_model.sv */
`timescale 1ns/10ps
module idac_mst_model #(
    parameter int HALF = 625 // clk cycles per clock phase, keeps the rate under 100 kHz
)
(
    // clock
    clk,
    // serial bus, sda_rel high = line released
    sda_in,
    scl,
    sda_rel
);
    input wire logic clk;
    input wire logic sda_in;
    output logic scl;
    output logic sda_rel;

    ////////////////////////////////////////////////////////////////////////////////
    // idle bus: both lines released
    initial begin
        scl = 1'b1;
        sda_rel = 1'b1;
    end

    // wait n clocks, then step off the edge
    task automatic hw(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // start or repeated start; the data line changes well after any clock fall
    task automatic start();
        sda_rel = 1'b1;
        hw(HALF);
        scl = 1'b1;
        hw(HALF);
        sda_rel = 1'b0;
        hw(HALF);
        scl = 1'b0;
        hw(2);
    endtask

    // stop, then leave the bus free before anything else
    task automatic stop();
        sda_rel = 1'b0;
        hw(HALF);
        scl = 1'b1;
        hw(HALF);
        sda_rel = 1'b1;
        hw(HALF);
    endtask

    // one clock pulse, data sampled while the clock is high
    task automatic pulse(output logic s);
        hw(HALF);
        scl = 1'b1;
        hw(HALF / 2);
        s = sda_in;
        hw(HALF - HALF / 2);
        scl = 1'b0;
        hw(2);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // byte out, msb first, then the device's acknowledge
    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            sda_rel = b[i];
            pulse(s);
        end
        sda_rel = 1'b1;
        pulse(s);
        ack = ~s;
    endtask

    // byte in, then acknowledge or, on the last byte, not-acknowledge
    task automatic rbyte(input logic last, output logic [7:0] b);
        logic s;
        sda_rel = 1'b1;
        for (int i = 7; i >= 0; i--) begin
            pulse(b[i]);
        end
        // the ack level stays until the next byte or the stop takes the line
        sda_rel = last;
        pulse(s);
    endtask
endmodule

/* test/testbench.sv */
`timescale 1ns/10ps
module testbench
    import idac_pkg::*;
;
    localparam logic [3:0] ADR_UP = IDAC_ADDR_HI_DEF[6:3];
    logic clk;
    logic rst_b;
    logic scl;
    logic sda_rel;
    logic sda_wire;
    logic sda_out;
    logic sda_oe_b;
    logic [2:0] pins;
    logic supply_dip;
    logic [3:0] port_level_in;
    logic [3:0] port_out;
    logic [3:0] port_drive_oe_b;
    logic scale_from_supply;
    logic supply_loss_flag;
    logic [7:0] ch [5];
    int num_errors = 0;
    int cmp_count = 0;
    int cyc = 0;

    ////////////////////////////////////////////////////////////////////////////////
    // wired-and data line with pull-up; the device only ever pulls low
    assign sda_wire = sda_rel & (sda_oe_b | sda_out);

    // phases cut to 16 clocks: the slave only oversamples, and full-rate phases
    // would run far past the cycle budget of this bench
    idac_mst_model #(.HALF(16)) mst_u (.clk(clk), .sda_in(sda_wire), .scl(scl),
        .sda_rel(sda_rel));

    idac_top dut_u (.clk(clk), .rst_b(rst_b), .scl_in(scl), .sda_in(sda_wire),
        .sda_out(sda_out), .sda_oe_b(sda_oe_b), .slave_id_pin0(pins[0]),
        .slave_id_pin1(pins[1]), .slave_id_pin2(pins[2]), .supply_dip(supply_dip),
        .port_level_in(port_level_in), .port_out(port_out),
        .port_drive_oe_b(port_drive_oe_b), .scale_from_supply(scale_from_supply),
        .channel0_code(ch[0]), .channel1_code(ch[1]), .channel2_code(ch[2]),
        .channel3_code(ch[3]), .channel4_code(ch[4]), .supply_loss_flag(supply_loss_flag));

    // 125 MHz clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // hang guard, well above the expected run length
    always @(posedge clk) begin
        cyc++;
        if (cyc == 30000) begin
            num_errors++;
            close_out();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: %s got %b expected %b", $time, what, got, exp);
        end
    endtask

    // control view, channel codes, and the never-high outputs
    task automatic chk_bank(input logic [7:0] ctl, input logic [7:0] e [5]);
        chk8({scale_from_supply, 3'h0, ~port_drive_oe_b}, {ctl[7], 3'h0, ctl[3:0]}, "control");
        for (int i = 0; i < 5; i++) begin
            chk8(ch[i], e[i], "channel code");
        end
        chk8({port_out, 3'h0, sda_out}, 8'h00, "pull-down values");
    endtask

    // addressed write; stp low leaves the frame open for a repeated start
    task automatic wr(input logic [2:0] id, input logic [7:0] sub, input logic [7:0] d [$],
        input logic exp_ack, input logic stp);
        logic a;
        mst_u.start();
        mst_u.wbyte({ADR_UP, id, 1'b0}, a);
        chk1(a, exp_ack, "address ack");
        mst_u.wbyte(sub, a);
        chk1(a, exp_ack, "sub address ack");
        foreach (d[i]) begin
            mst_u.wbyte(d[i], a);
            chk1(a, exp_ack, "data ack");
        end
        if (stp) begin
            mst_u.stop();
        end
    endtask

    // two status bytes in one frame, then stop
    task automatic rd(input logic [7:0] e);
        logic a;
        logic [7:0] b;
        mst_u.start();
        mst_u.wbyte({ADR_UP, pins, 1'b1}, a);
        chk1(a, 1'b1, "read address ack");
        mst_u.rbyte(1'b0, b);
        chk8(b, e, "status first");
        mst_u.rbyte(1'b1, b);
        chk8(b, e, "status second");
        mst_u.stop();
        tick(4);
    endtask

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [7:0] v;
        rst_b = 1'b0;
        pins = 3'h5;
        supply_dip = 1'b0;
        port_level_in = 4'h0;
        tick(4);
        rst_b = 1'b1;
        tick(1);
        chk_bank(8'h00, '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
        chk1(supply_loss_flag, 1'b1, "loss flag at power-up");
        chk1(sda_oe_b, 1'b1, "data line released");
        $display("test reset done");
        // upper sub address bits set; one burst fills the whole bank
        wr(3'h5, 8'hF8, {8'h8A, 8'h00, 8'hFF, 8'h55, 8'hFC, 8'h01}, 1'b1, 1'b1);
        chk_bank(8'h8A, '{8'h00, 8'hFF, 8'h55, 8'hFC, 8'h01});
        $display("test burst done");
        // every select address, only the strapped one answers
        for (int i = 0; i < 8; i++) begin
            v = 8'h10 + 8'(i);
            wr(3'(i), 8'h01, {v}, i == 5, 1'b1);
        end
        chk8(ch[0], 8'h15, "addressed channel");
        // other strapping: the old address goes dead, the new one answers
        pins = 3'h2;
        wr(3'h5, 8'h01, {8'h99}, 1'b0, 1'b1);
        wr(3'h2, 8'h01, {8'h66}, 1'b1, 1'b1);
        chk8(ch[0], 8'h66, "restrapped channel");
        pins = 3'h5;
        $display("test address done");
        // pointer walks past the last channel, wraps to the control byte
        wr(3'h5, 8'h05, {8'hC3, 8'h11, 8'h22, 8'h01}, 1'b1, 1'b1);
        chk_bank(8'h01, '{8'h66, 8'hFF, 8'h55, 8'hFC, 8'hC3});
        $display("test wrap done");
        // ports as inputs, status via repeated start
        port_level_in = 4'h5;
        wr(3'h5, 8'h00, {8'h00}, 1'b1, 1'b0);
        rd(8'h85);
        chk1(supply_loss_flag, 1'b0, "loss flag after read");
        port_level_in = 4'hA;
        rd(8'h0A);
        supply_dip = 1'b1;
        tick(1);
        supply_dip = 1'b0;
        tick(2);
        chk1(supply_loss_flag, 1'b1, "loss flag after dip");
        rd(8'h8A);
        $display("test status done");
        // reset in mid-run clears the bank again
        rst_b = 1'b0;
        tick(2);
        rst_b = 1'b1;
        tick(1);
        chk_bank(8'h00, '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
        chk1(supply_loss_flag, 1'b1, "loss flag after reset");
        $display("test second reset done");
        close_out();
    end
endmodule
